// ==== rtl/pps_port_sequencer.sv ====
// port sequencer: modes, detection, classification, power and fault budget
// Summary of operation
// - mode field 01 selects manual operation under software command.
// - manual detect and classify bits self-clear when detection or classification ends.
// - detect and classify requested together: detection runs first.
// - power-up command wins over detection and classification; powered port ignores requests.
// - mode 00 removes power, clears events and status, stops activity.
// - in shutdown registers work but detect, classify, power-up ignored.
// - detection end sets done flag and result code; clear on read.
// - load stability check off after reset, on only when enabled.
// - cadence mode waits 2.0 s after failed detection; first is immediate.
// - high-cap enable is software bit, strap latched at reset release.
// - classification end sets done flag and class; clear on read.
// - class current above 51 mA without class 5: no power, idle.
// - class from current bands; gaps resolve to lower class.
// - strap low enables class 5 above class 4 limit, picks limit code.
// - class 0-3 ends; class 4 or 5 gets one mark phase and second event.
// - powering clears fault timer; startup expiry gives power good.
// - power good drops on power off; change flag both ways.
// - power-down command removes port power at once.
// - fault budget counts up on overcurrent, down slower; limit trips.
// - after trip counter drains; repower only at zero unless disabled.
// - limit code from class unless manual select, then software.
// - startup phase uses fixed 420 mA limit code.
// - mode field 11 selects automatic, also the mode after reset.
// - mode field 10 selects semiautomatic, power waits for command.
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module pps_port_sequencer
	import pps_pkg::*;
#(
	parameter int unsigned BACKOFF_CYCLES = BACKOFF_CYC,
	parameter int unsigned START_CYCLES = START_CYC,
	parameter int unsigned TICK_CYCLES = TICK_CYC,
	parameter int unsigned MARK_CYCLES = MARK_CYC
)
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire pps_bus_t i_bus,
	output logic [7:0] o_rdata,
	input wire pps_pins_t i_pins,
	input wire logic i_det_done,
	input wire logic [2:0] i_det_code,
	input wire logic i_class_done,
	input wire logic [6:0] i_class_ma,
	output logic o_port_power,
	output logic o_detect_active,
	output logic o_classify_active,
	output logic o_mark_active,
	output logic [2:0] o_current_limit_level,
	output logic o_load_stability_enable,
	output logic o_high_cap_detect_enable
);
	localparam int TW = 27;
	localparam int KW = 16;

	function automatic logic hit(input logic s, input logic [7:0] a,
		input logic [7:0] r);
		return s && (a == r);
	endfunction

	function automatic logic [2:0] class_of(input logic [6:0] ma,
		input logic c5);
		logic [2:0] c;
		c = 3'h0;
		if (ma > CLS_MAX_MA)
			c = c5 ? 3'h5 : CLASS_INVALID;
		else if (ma > CLS4_TOP)
			c = c5 ? 3'h5 : 3'h4;
		else if (ma > CLS3_TOP)
			c = 3'h4;
		else if (ma > CLS2_TOP)
			c = 3'h3;
		else if (ma > CLS1_TOP)
			c = 3'h2;
		else if (ma > CLS0_TOP)
			c = 3'h1;
		return c;
	endfunction

	function automatic logic [2:0] limit_of(input logic [2:0] c,
		input logic a, input logic b);
		logic [2:0] l;
		l = LIM_LOW;
		if (c == 3'h4)
			l = LIM_CLS4;
		else if (c == 3'h5)
		begin
			if (!a && !b)
				l = LIM_AB;
			else if (!a)
				l = LIM_A;
			else
				l = LIM_B;
		end
		return l;
	endfunction

	pps_state_t state_q, state_d, fin;
	pps_mode_t mode_q;
	pps_pins_t s1_q, s2_q, s3_q, filt_q;
	logic [2:0] lat_cnt_q;
	logic det_req_q, cls_req_q, det_ok_q, backoff_q, hicap_q, lsc_q;
	logic lim_sel_q, rw_dis_q, lock_q, strap_a_q, strap_b_q;
	logic det_done_q, cls_done_q, power_good_change_flag_q, flt_q, power_good_flag_q;
	logic [2:0] det_code_q, class_q, limit_code_q, dec_rate_q, dec_cnt_q;
	logic [7:0] flt_limit_q, fault_q, rdata_d;
	logic [TW-1:0] timer_q, tlim;
	logic [KW-1:0] tick_cnt_q;

	wire [7:0] wd = i_bus.wdata;
	wire ready = lat_cnt_q == LAT_DONE;
	wire shut = mode_q == MODE_SHUT;
	wire is_auto = mode_q == MODE_AUTO;
	wire mode_wr = hit(i_bus.wr, i_bus.addr, REG_MODE);
	wire going_shut = mode_wr && (wd[1:0] == MODE_SHUT);
	wire mode_entry = mode_wr && (wd[1:0] != mode_q);
	wire powered = (state_q == ST_START) || (state_q == ST_POWER);
	wire pup_ok = !lock_q || rw_dis_q || (fault_q == 8'h00);
	wire cmd_wr = hit(i_bus.wr, i_bus.addr, REG_PWR_CMD);
	wire pup_cmd = cmd_wr && wd[BIT_PUP] && !shut && !going_shut
		&& !powered && pup_ok && ready && !wd[BIT_PDN];
	wire pdn_cmd = cmd_wr && wd[BIT_PDN];
	wire tick = tick_cnt_q == KW'(TICK_CYCLES - 1);
	wire over = (state_q == ST_START) ? filt_q.over_limit : filt_q.over_cut;
	wire [8:0] fault_up = {1'b0, fault_q} + 9'h001;
	wire trip = powered && tick && over && (fault_up >= {1'b0, flt_limit_q});
	wire off_now = powered && (pdn_cmd || going_shut || trip);
	wire c5_en = !strap_a_q || !strap_b_q;
	wire [2:0] cls_code = class_of(i_class_ma, c5_en);
	wire two_event = (cls_code == 3'h4) || (cls_code == 3'h5);
	wire cls_ok = cls_code != CLASS_INVALID;
	wire detect_done_flag = (state_q == ST_DETECT) && i_det_done;
	wire cls1_end = (state_q == ST_CLASS1) && i_class_done;
	wire cls_end = (cls1_end && !two_event)
		|| ((state_q == ST_CLASS2) && i_class_done);
	wire timer_done = timer_q == tlim;
	wire enter_start = (state_d == ST_START) && (state_q != ST_START);
	wire req_wr = hit(i_bus.wr, i_bus.addr, REG_DC_EN) && !shut && !powered;

	// pin synchroniser, a change counts once stages two and three agree
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			s1_q <= PINS_RST;
			s2_q <= PINS_RST;
			s3_q <= PINS_RST;
			filt_q <= PINS_RST;
		end
		else
		begin
			s1_q <= i_pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
		end
	end

	// strap latch after reset release
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
			lat_cnt_q <= 3'h0;
		else if (!ready)
			lat_cnt_q <= lat_cnt_q + 3'h1;
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			hicap_q <= 1'b0;
			backoff_q <= 1'b0;
			strap_a_q <= 1'b1;
			strap_b_q <= 1'b1;
		end
		else if (lat_cnt_q == LAT_LOAD)
		begin
			hicap_q <= filt_q.high_cap;
			backoff_q <= filt_q.midspan;
			strap_a_q <= filt_q.strap_a;
			strap_b_q <= filt_q.strap_b;
		end
		else if (i_bus.wr)
		begin
			if (i_bus.addr == REG_HICAP)
				hicap_q <= wd[BIT_HICAP];
			if (i_bus.addr == REG_BACKOFF)
				backoff_q <= wd[BIT_BCK];
		end
	end

	// software configuration
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			mode_q <= MODE_AUTO;
			lsc_q <= 1'b0;
			lim_sel_q <= 1'b0;
			rw_dis_q <= 1'b0;
			dec_rate_q <= DEC_RATE_RST;
			flt_limit_q <= FLT_LIMIT_RST;
		end
		else if (i_bus.wr)
		begin
			if (mode_wr)
				mode_q <= pps_mode_t'(wd[1:0]);
			if (i_bus.addr == REG_LSC)
				lsc_q <= wd[BIT_LSC];
			if (i_bus.addr == REG_LIM_SEL)
				lim_sel_q <= wd[BIT_LIMSEL];
			if (i_bus.addr == REG_RESTART)
			begin
				rw_dis_q <= wd[BIT_RWDIS];
				dec_rate_q <= wd[2:0];
			end
			if (i_bus.addr == REG_FLT_TIME)
				flt_limit_q <= wd;
		end
	end

	// detect and classify request bits
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			det_req_q <= 1'b1;
			cls_req_q <= 1'b1;
		end
		else if (mode_entry)
		begin
			det_req_q <= wd[1:0] == MODE_AUTO;
			cls_req_q <= wd[1:0] == MODE_AUTO;
		end
		else if (req_wr)
		begin
			det_req_q <= wd[BIT_DET];
			cls_req_q <= wd[BIT_CLS];
		end
		else if (mode_q == MODE_MANUAL)
		begin
			if (detect_done_flag)
				det_req_q <= 1'b0;
			if (cls_end)
				cls_req_q <= 1'b0;
		end
		else if ((mode_q == MODE_SEMI) && pdn_cmd)
		begin
			det_req_q <= 1'b0;
			cls_req_q <= 1'b0;
		end
	end

	always_comb
	begin
		fin = ST_IDLE;
		if (cls_ok && is_auto && det_ok_q && pup_ok)
			fin = ST_START;
		case (state_q)
			ST_WAIT: tlim = TW'(BACKOFF_CYCLES - 1);
			ST_MARK: tlim = TW'(MARK_CYCLES - 1);
			default: tlim = TW'(START_CYCLES - 1);
		endcase
	end

	// port sequence
	always_comb
	begin
		state_d = state_q;
		if (going_shut || shut || off_now)
			state_d = ST_IDLE;
		else if (pup_cmd)
			state_d = ST_START;
		else
			case (state_q)
				ST_IDLE:
					if (ready && det_req_q)
						state_d = ST_DETECT;
					else if (ready && cls_req_q)
						state_d = ST_CLASS1;
				ST_WAIT:
					if (timer_done)
						state_d = ST_IDLE;
				ST_DETECT:
					if (detect_done_flag)
					begin
						if (i_det_code != DET_VALID)
							state_d = backoff_q ? ST_WAIT : ST_IDLE;
						else if (cls_req_q)
							state_d = ST_CLASS1;
						else if (is_auto && pup_ok)
							state_d = ST_START;
						else
							state_d = ST_IDLE;
					end
				ST_CLASS1:
					if (cls1_end)
						state_d = two_event ? ST_MARK : fin;
				ST_MARK:
					if (timer_done)
						state_d = ST_CLASS2;
				ST_CLASS2:
					if (i_class_done)
						state_d = fin;
				ST_START:
					if (timer_done)
						state_d = ST_POWER;
				ST_POWER:
					state_d = ST_POWER;
				default:
					state_d = ST_IDLE;
			endcase
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rstn || (state_d != state_q))
			timer_q <= '0;
		else
			timer_q <= timer_q + TW'(1);
	end

	// outputs driven from the next state, the two enables from their register bits
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			o_port_power <= 1'b0;
			power_good_flag_q <= 1'b0;
			o_detect_active <= 1'b0;
			o_classify_active <= 1'b0;
			o_mark_active <= 1'b0;
			o_current_limit_level <= LIM_START;
			o_load_stability_enable <= 1'b0;
			o_high_cap_detect_enable <= 1'b0;
		end
		else
		begin
			o_port_power <= (state_d == ST_START) || (state_d == ST_POWER);
			power_good_flag_q <= state_d == ST_POWER;
			o_detect_active <= state_d == ST_DETECT;
			o_classify_active <= (state_d == ST_CLASS1)
				|| (state_d == ST_CLASS2);
			o_mark_active <= state_d == ST_MARK;
			o_current_limit_level <= (state_d == ST_START) ? LIM_START
				: limit_code_q;
			o_load_stability_enable <= lsc_q;
			o_high_cap_detect_enable <= hicap_q;
		end
	end

	// event flags, a set wins over clear-on-read
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn || going_shut)
		begin
			det_done_q <= 1'b0;
			cls_done_q <= 1'b0;
			power_good_change_flag_q <= 1'b0;
			flt_q <= 1'b0;
		end
		else
		begin
			if (detect_done_flag)
				det_done_q <= 1'b1;
			else if (hit(i_bus.rd, i_bus.addr, REG_DC_EV_COR))
				det_done_q <= 1'b0;
			if (cls_end)
				cls_done_q <= 1'b1;
			else if (hit(i_bus.rd, i_bus.addr, REG_DC_EV_COR))
				cls_done_q <= 1'b0;
			if (enter_start || off_now)
				power_good_change_flag_q <= 1'b1;
			else if (hit(i_bus.rd, i_bus.addr, REG_PWR_EV_COR))
				power_good_change_flag_q <= 1'b0;
			if (trip)
				flt_q <= 1'b1;
			else if (hit(i_bus.rd, i_bus.addr, REG_FLT_EV_COR))
				flt_q <= 1'b0;
		end
	end

	// result status
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn || going_shut)
		begin
			det_code_q <= 3'h0;
			class_q <= 3'h0;
			det_ok_q <= 1'b0;
		end
		else
		begin
			if (detect_done_flag)
			begin
				det_code_q <= i_det_code;
				det_ok_q <= i_det_code == DET_VALID;
			end
			else if (off_now)
				det_ok_q <= 1'b0;
			if (cls_end || cls1_end)
				class_q <= cls_code;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
			limit_code_q <= LIM_LOW;
		else if (lim_sel_q)
		begin
			if (hit(i_bus.wr, i_bus.addr, REG_LIM_CODE))
				limit_code_q <= wd[2:0];
		end
		else if (cls_end && cls_ok)
			limit_code_q <= limit_of(cls_code, strap_a_q, strap_b_q);
	end

	// fault budget tick divider
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn || tick)
			tick_cnt_q <= '0;
		else
			tick_cnt_q <= tick_cnt_q + KW'(1);
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			fault_q <= 8'h00;
			dec_cnt_q <= 3'h0;
		end
		else if (enter_start)
			fault_q <= 8'h00;
		else if (tick)
		begin
			if (powered && over)
				fault_q <= trip ? flt_limit_q : fault_up[7:0];
			else if (dec_cnt_q >= dec_rate_q)
			begin
				dec_cnt_q <= 3'h0;
				if (fault_q != 8'h00)
					fault_q <= fault_q - 8'h01;
			end
			else
				dec_cnt_q <= dec_cnt_q + 3'h1;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
			lock_q <= 1'b0;
		else if (trip)
			lock_q <= 1'b1;
		else if (fault_q == 8'h00)
			lock_q <= 1'b0;
	end

	// register read
	always_comb
	begin
		rdata_d = 8'h00;
		case (i_bus.addr)
			REG_PWR_EV, REG_PWR_EV_COR: rdata_d[BIT_PG] = power_good_change_flag_q;
			REG_DC_EV, REG_DC_EV_COR:
			begin
				rdata_d[BIT_DET] = det_done_q;
				rdata_d[BIT_CLS] = cls_done_q;
			end
			REG_FLT_EV, REG_FLT_EV_COR: rdata_d[BIT_FLT] = flt_q;
			REG_DC_STAT:
			begin
				rdata_d[DET_LSB +: 3] = det_code_q;
				rdata_d[CLASS_LSB +: 3] = class_q;
			end
			REG_PWR_STAT:
			begin
				rdata_d[BIT_PG] = power_good_flag_q;
				rdata_d[BIT_PWR] = o_port_power;
			end
			REG_MODE: rdata_d[1:0] = mode_q;
			REG_DC_EN:
			begin
				rdata_d[BIT_DET] = det_req_q;
				rdata_d[BIT_CLS] = cls_req_q;
			end
			REG_BACKOFF: rdata_d[BIT_BCK] = backoff_q;
			REG_FLT_TIME: rdata_d = flt_limit_q;
			REG_LIM_SEL: rdata_d[BIT_LIMSEL] = lim_sel_q;
			REG_HICAP: rdata_d[BIT_HICAP] = hicap_q;
			REG_LSC: rdata_d[BIT_LSC] = lsc_q;
			REG_LIM_CODE: rdata_d[2:0] = limit_code_q;
			REG_RESTART:
			begin
				rdata_d[BIT_RWDIS] = rw_dis_q;
				rdata_d[2:0] = dec_rate_q;
			end
			default: rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
			o_rdata <= 8'h00;
		else
			o_rdata <= i_bus.rd ? rdata_d : 8'h00;
	end
endmodule
`default_nettype wire

// ==== rtl/pps_pkg.sv ====
// constants, register map and types shared by the port sequencer
package pps_pkg;
	localparam logic [7:0] REG_PWR_EV = 8'h02;
	localparam logic [7:0] REG_PWR_EV_COR = 8'h03;
	localparam logic [7:0] REG_DC_EV = 8'h04;
	localparam logic [7:0] REG_DC_EV_COR = 8'h05;
	localparam logic [7:0] REG_FLT_EV = 8'h06;
	localparam logic [7:0] REG_FLT_EV_COR = 8'h07;
	localparam logic [7:0] REG_DC_STAT = 8'h0C;
	localparam logic [7:0] REG_PWR_STAT = 8'h10;
	localparam logic [7:0] REG_MODE = 8'h12;
	localparam logic [7:0] REG_DC_EN = 8'h14;
	localparam logic [7:0] REG_BACKOFF = 8'h15;
	localparam logic [7:0] REG_FLT_TIME = 8'h16;
	localparam logic [7:0] REG_LIM_SEL = 8'h17;
	localparam logic [7:0] REG_PWR_CMD = 8'h19;
	localparam logic [7:0] REG_HICAP = 8'h23;
	localparam logic [7:0] REG_LSC = 8'h29;
	localparam logic [7:0] REG_LIM_CODE = 8'h2A;
	localparam logic [7:0] REG_RESTART = 8'h2B;
	localparam int BIT_DET = 0;
	localparam int BIT_CLS = 4;
	localparam int BIT_PG = 4;
	localparam int BIT_PWR = 0;
	localparam int BIT_FLT = 0;
	localparam int BIT_LIMSEL = 2;
	localparam int BIT_PUP = 0;
	localparam int BIT_PDN = 4;
	localparam int BIT_HICAP = 5;
	localparam int BIT_LSC = 4;
	localparam int BIT_BCK = 0;
	localparam int BIT_RWDIS = 7;
	localparam int DET_LSB = 0;
	localparam int CLASS_LSB = 4;
	localparam logic [7:0] FLT_LIMIT_RST = 8'h3C;
	localparam logic [2:0] DEC_RATE_RST = 3'h1;
	localparam logic [2:0] DET_VALID = 3'h4;
	localparam logic [2:0] CLASS_INVALID = 3'h6;
	localparam logic [2:0] LIM_LOW = 3'h0;
	localparam logic [2:0] LIM_CLS4 = 3'h1;
	localparam logic [2:0] LIM_A = 3'h5;
	localparam logic [2:0] LIM_B = 3'h6;
	localparam logic [2:0] LIM_AB = 3'h7;
	localparam logic [2:0] LIM_START = 3'h0;
	localparam logic [6:0] CLS0_TOP = 7'h07;
	localparam logic [6:0] CLS1_TOP = 7'h0F;
	localparam logic [6:0] CLS2_TOP = 7'h18;
	localparam logic [6:0] CLS3_TOP = 7'h22;
	localparam logic [6:0] CLS4_TOP = 7'h2D;
	localparam logic [6:0] CLS_MAX_MA = 7'h33;
	localparam logic [2:0] LAT_LOAD = 3'h4;
	localparam logic [2:0] LAT_DONE = 3'h5;
	localparam int CLOCK_HZ = 40000000;
	localparam int BACKOFF_TIME_MS = 2000;
	localparam int BACKOFF_CYC = CLOCK_HZ / 1000 * BACKOFF_TIME_MS;
	localparam int START_TIME_MS = 60;
	localparam int START_CYC = CLOCK_HZ / 1000 * START_TIME_MS;
	localparam int TICK_TIME_US = 1000;
	localparam int TICK_CYC = CLOCK_HZ / 1000000 * TICK_TIME_US;
	localparam int MARK_TIME_US = 10;
	localparam int MARK_CYC = CLOCK_HZ / 1000000 * MARK_TIME_US;
	typedef enum logic [1:0] {
		MODE_SHUT = 2'h0,
		MODE_MANUAL = 2'h1,
		MODE_SEMI = 2'h2,
		MODE_AUTO = 2'h3
	} pps_mode_t;
	typedef enum logic [2:0] {
		ST_IDLE, ST_WAIT, ST_DETECT, ST_CLASS1,
		ST_MARK, ST_CLASS2, ST_START, ST_POWER
	} pps_state_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pps_bus_t;
	typedef struct packed {
		logic midspan;
		logic high_cap;
		logic strap_a;
		logic strap_b;
		logic over_limit;
		logic over_cut;
	} pps_pins_t;
	localparam pps_pins_t PINS_RST = 6'h3C;
endpackage

// ==== sim/pps_pd_model.sv ====
// powered device model answering detection and classification probes
`timescale 1ns/100ps
`default_nettype none
module pps_pd_model (
	input wire logic i_clock,
	input wire logic i_detect_active,
	input wire logic i_classify_active,
	input wire logic [2:0] i_code,
	input wire logic [6:0] i_ma,
	input wire logic [3:0] i_delay,
	output logic o_det_done,
	output logic [2:0] o_det_code,
	output logic o_class_done,
	output logic [6:0] o_class_ma
);
	logic [3:0] cnt_q = 4'h0;
	logic done_q = 1'b0;
	logic [1:0] ph_q = 2'h0;
	logic [1:0] ph;
	assign ph = {i_detect_active, i_classify_active};
	// one answer per probe phase, after a settable delay
	always_ff @(posedge i_clock)
	begin
		ph_q <= ph;
		o_det_done <= 1'b0;
		o_class_done <= 1'b0;
		o_det_code <= ~i_code;
		o_class_ma <= ~i_ma;
		if (ph == 2'h0 || ph != ph_q)
		begin
			cnt_q <= 4'h0;
			done_q <= 1'b0;
		end
		else if (!done_q)
		begin
			cnt_q <= cnt_q + 4'h1;
			if (cnt_q >= i_delay)
			begin
				done_q <= 1'b1;
				o_det_done <= i_detect_active;
				o_class_done <= i_classify_active;
				o_det_code <= i_code;
				o_class_ma <= i_ma;
			end
		end
	end
endmodule
`default_nettype wire

// ==== sim/pps_port_sequencer_asserts.sv ====
// concurrent checks on the port sequencer ports
`timescale 1ns/100ps
`default_nettype none
module pps_port_sequencer_chk
	import pps_pkg::*;
#(
	parameter int unsigned MARK_CYCLES = MARK_CYC
)
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire pps_bus_t i_bus,
	input wire logic [7:0] o_rdata,
	input wire logic i_det_done,
	input wire logic o_port_power,
	input wire logic o_detect_active,
	input wire logic o_classify_active,
	input wire logic o_mark_active,
	input wire logic [2:0] o_current_limit_level,
	input wire logic o_load_stability_enable,
	input wire logic o_high_cap_detect_enable
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	logic shut_q;
	int unsigned mark_q = 0;
	// track shutdown mode and the length of the mark phase
	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
			shut_q <= 1'b0;
		else if (i_bus.wr && i_bus.addr == REG_MODE)
			shut_q <= i_bus.wdata[1:0] == 2'h0;
		mark_q <= o_mark_active ? mark_q + 1 : 0;
	end
	sequence s_mode_shut;
		i_bus.wr && i_bus.addr == REG_MODE && i_bus.wdata[1:0] == 2'h0;
	endsequence
	sequence s_power_down;
		i_bus.wr && i_bus.addr == REG_PWR_CMD && i_bus.wdata[BIT_PDN];
	endsequence
	sequence s_port_idle;
		!o_port_power && !o_detect_active && !o_classify_active;
	endsequence
	a_rdata_idle: assert property (
		!i_bus.rd |=> o_rdata == 8'h00) else $error("stray read data");
	a_start_limit: assert property (
		$rose(o_port_power) |->
		(o_current_limit_level == LIM_START || !o_port_power)[*8])
		else $error("startup limit wrong");
	a_phase_excl: assert property (
		!(o_detect_active && o_classify_active)) else $error("phase overlap");
	a_power_quiet: assert property (
		o_port_power |-> !o_detect_active && !o_classify_active &&
		!o_mark_active) else $error("probing while powered");
	a_detect_done_flag: assert property (
		o_detect_active && i_det_done |=> !o_detect_active)
		else $error("detection not ended");
	a_mark_len: assert property (
		$fell(o_mark_active) && !$past(i_bus.wr) |-> o_classify_active &&
		mark_q inside {[MARK_CYCLES:MARK_CYCLES + 1]})
		else $error("mark phase wrong");
	a_power_down: assert property (
		s_power_down |-> ##[1:2] !o_port_power) else $error("power stays on");
	a_shut_stop: assert property (
		s_mode_shut |-> ##[1:2] s_port_idle) else $error("shutdown not idle");
	a_shut_hold: assert property (
		shut_q && $past(shut_q) |-> s_port_idle) else $error("shutdown active");
	a_lsc_copy: assert property (
		i_bus.wr && i_bus.addr == REG_LSC |-> ##2
		o_load_stability_enable == $past(i_bus.wdata[BIT_LSC], 2))
		else $error("stability enable wrong");
	a_hicap_copy: assert property (
		i_bus.wr && i_bus.addr == REG_HICAP |-> ##2
		o_high_cap_detect_enable == $past(i_bus.wdata[BIT_HICAP], 2))
		else $error("high cap enable wrong");
endmodule
bind pps_port_sequencer pps_port_sequencer_chk #(.MARK_CYCLES(MARK_CYCLES))
	chk_u (.i_clock(i_clock), .i_rstn(i_rstn), .i_bus(i_bus),
	.o_rdata(o_rdata), .i_det_done(i_det_done), .o_port_power(o_port_power),
	.o_detect_active(o_detect_active), .o_classify_active(o_classify_active),
	.o_mark_active(o_mark_active),
	.o_current_limit_level(o_current_limit_level),
	.o_load_stability_enable(o_load_stability_enable),
	.o_high_cap_detect_enable(o_high_cap_detect_enable));
`default_nettype wire

// ==== sim/pps_port_sequencer_test.sv ====
// self-checking bench for the port sequencer
`timescale 1ns/100ps
`default_nettype none
module pps_port_sequencer_test
	import pps_pkg::*;
;
	localparam int BK = 200;
	localparam int ST = 50;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	pps_bus_t bus = '0;
	pps_pins_t pins = PINS_RST;
	logic [2:0] code = 3'h1;
	logic [6:0] ma = 7'h00;
	logic [3:0] dly = 4'h2;
	logic [7:0] rdata;
	logic [2:0] lim, det_code;
	logic pwr, det_act, cls_act, mark_act, lsc, hicap, det_done, cls_done;
	logic [6:0] cls_ma;
	int mismatches = 0;
	int num_checks = 0;
	int cyc = 0;
	always #12.5 clock = ~clock;
	pps_port_sequencer #(.BACKOFF_CYCLES(BK), .START_CYCLES(ST),
		.TICK_CYCLES(4), .MARK_CYCLES(8)) dut_u (
		.i_clock(clock), .i_rstn(rstn), .i_bus(bus), .o_rdata(rdata),
		.i_pins(pins), .i_det_done(det_done), .i_det_code(det_code),
		.i_class_done(cls_done), .i_class_ma(cls_ma), .o_port_power(pwr),
		.o_detect_active(det_act), .o_classify_active(cls_act),
		.o_mark_active(mark_act), .o_current_limit_level(lim),
		.o_load_stability_enable(lsc), .o_high_cap_detect_enable(hicap));
	pps_pd_model pd_u (.i_clock(clock), .i_detect_active(det_act),
		.i_classify_active(cls_act), .i_code(code), .i_ma(ma), .i_delay(dly),
		.o_det_done(det_done), .o_det_code(det_code),
		.o_class_done(cls_done), .o_class_ma(cls_ma));
	task automatic end_sim;
		if (mismatches == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask
	task automatic rd_raw(input logic [7:0] a, output logic [7:0] got);
		@(posedge clock);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clock);
		bus.rd <= 1'b0;
		@(negedge clock);
		got = rdata;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd_raw(a, v);
		chk(v, exp);
	endtask
	function automatic logic sig(input int sel);
		case (sel)
			0: return pwr;
			1: return det_act;
			2: return cls_act;
			default: return mark_act;
		endcase
	endfunction
	// wait for a level, bounded, then compare it
	task automatic wait_on(input int sel, input logic val, output int n);
		n = 0;
		while (n < 400 && sig(sel) !== val)
		begin
			@(negedge clock);
			n++;
		end
		chk({7'h00, sig(sel)}, {7'h00, val});
	endtask
	function automatic logic [2:0] cls_of(input logic [6:0] m, input logic c5);
		if (m > 7'h33) return c5 ? 3'h5 : CLASS_INVALID;
		if (m > 7'h2D) return c5 ? 3'h5 : 3'h4;
		if (m > 7'h22) return 3'h4;
		if (m > 7'h18) return 3'h3;
		if (m > 7'h0F) return 3'h2;
		if (m > 7'h07) return 3'h1;
		return 3'h0;
	endfunction
	function automatic logic [2:0] lim_of(input logic [2:0] c, input logic a,
		input logic b);
		if (c == 3'h4) return 3'h1;
		if (c != 3'h5) return 3'h0;
		return {1'b1, ~b, ~a};
	endfunction
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			mismatches++;
			end_sim;
		end
	end
	initial
	begin
		logic hc, sa, sb, c5;
		logic [2:0] lc;
		logic [7:0] v;
		int n;
		void'($urandom(32'h805E3E17));
		hc = 1'($urandom);
		pins <= '{1'b1, hc, 1'b1, 1'b1, 1'b0, 1'b0};
		repeat (4) @(posedge clock);
		rstn <= 1'b1;
		wait_on(1, 1'b1, n);
		chk({7'h00, n < 12}, 8'h01);
		chk({7'h00, hicap}, {7'h00, hc});
		chk({7'h00, lsc}, 8'h00);
		wait_on(1, 1'b0, n);
		code <= DET_VALID;
		ma <= 7'h23 + 7'($urandom % 11);
		wait_on(1, 1'b1, n);
		chk({7'h00, n >= BK - 1 && n <= BK + 12}, 8'h01);
		wait_on(3, 1'b1, n);
		wait_on(0, 1'b1, n);
		chk({5'h00, lim}, {5'h00, LIM_START});
		repeat (ST + 4) @(negedge clock);
		chk({5'h00, lim},
			{5'h00, lim_of(cls_of(ma, 1'b0), 1'b1, 1'b1)});
		rd(REG_PWR_STAT, 8'h11);
		rd(REG_DC_STAT, {1'b0, cls_of(ma, 1'b0), 1'b0, DET_VALID});
		rd(REG_DC_EV_COR, 8'h11);
		rd(REG_DC_EV_COR, 8'h00);
		rd(REG_PWR_EV_COR, 8'h10);
		rd(REG_MODE, 8'h03);
		rd(REG_FLT_TIME, FLT_LIMIT_RST);
		wr(REG_MODE, 8'h02);
		wr(REG_FLT_TIME, 8'h03);
		pins.over_cut <= 1'b1;
		wait_on(0, 1'b0, n);
		@(posedge clock);
		pins.over_cut <= 1'b0;
		rd(REG_FLT_EV_COR, 8'h01);
		rd(REG_PWR_STAT, 8'h00);
		rd(REG_PWR_EV_COR, 8'h10);
		wr(REG_PWR_CMD, 8'h01);
		@(negedge clock);
		chk({7'h00, pwr}, 8'h00);
		repeat (40) @(negedge clock);
		wr(REG_PWR_CMD, 8'h01);
		wait_on(0, 1'b1, n);
		wr(REG_PWR_CMD, 8'h10);
		wait_on(0, 1'b0, n);
		{sa, sb} = 2'($urandom);
		c5 = !(sa && sb);
		code <= 3'h1;
		@(posedge clock);
		rstn <= 1'b0;
		pins <= '{1'b0, hc, sa, sb, 1'b0, 1'b0};
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		repeat (8) @(posedge clock);
		wr(REG_MODE, 8'h01);
		wait_on(1, 1'b0, n);
		rd(REG_DC_EN, 8'h00);
		code <= DET_VALID;
		lc = LIM_LOW;
		for (int i = 0; i < 6; i++)
		begin
			ma <= (i == 0) ? 7'h33 : (i == 1) ? 7'h34 : 7'($urandom);
			dly <= 4'($urandom % 10);
			wr(REG_DC_EN, 8'h11);
			wait_on(1, 1'b1, n);
			chk({7'h00, cls_act}, 8'h00);
			n = 0;
			do
			begin
				rd_raw(REG_DC_EN, v);
				n++;
			end while (v !== 8'h00 && n < 40);
			chk(v, 8'h00);
			rd(REG_DC_STAT, {1'b0, cls_of(ma, c5), 1'b0, DET_VALID});
			if (cls_of(ma, c5) != CLASS_INVALID)
				lc = lim_of(cls_of(ma, c5), sa, sb);
			rd(REG_LIM_CODE, {5'h00, lc});
			chk({7'h00, pwr}, 8'h00);
		end
		lc = 3'($urandom);
		wr(REG_LIM_SEL, 8'h04);
		wr(REG_LIM_CODE, {5'h00, lc});
		rd(REG_LIM_CODE, {5'h00, lc});
		wr(REG_PWR_CMD, 8'h01);
		wait_on(0, 1'b1, n);
		repeat (ST + 4) @(negedge clock);
		chk({5'h00, lim}, {5'h00, lc});
		wr(REG_DC_EN, 8'h11);
		@(negedge clock);
		chk({6'h00, det_act, cls_act}, 8'h00);
		wr(REG_MODE, 8'h00);
		wait_on(0, 1'b0, n);
		rd(REG_PWR_STAT, 8'h00);
		rd(REG_PWR_EV, 8'h00);
		wr(REG_PWR_CMD, 8'h01);
		wr(REG_DC_EN, 8'h11);
		@(negedge clock);
		chk({6'h00, pwr, det_act}, 8'h00);
		rd(REG_MODE, 8'h00);
		wr(REG_LSC, 8'h10);
		wr(REG_HICAP, {2'h0, ~hc, 5'h00});
		repeat (2) @(negedge clock);
		chk({6'h00, lsc, hicap}, {6'h00, 1'b1, ~hc});
		rd(8'h3F, 8'h00);
		end_sim;
	end
endmodule
`default_nettype wire
